// ==== core/working_regs.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "work_regs_consts.svh"
module working_regs
	import work_regs_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// Wishbone slave
	input  wire logic                    cyc_i,
	input  wire logic                    stb_i,
	input  wire logic                    we_i,
	input  wire logic [`WB_ADDR_W-1:0]   adr_i,
	input  wire logic [3:0]              sel_i,
	input  wire logic [31:0]             dat_i,
	output logic [31:0]                  dat_o,
	output logic                         ack_o,
	// Core datapath
	input  wire logic                    op_valid_i,
	input  wire work_regs_pkg::alu_op_t  op_i,
	input  wire work_regs_pkg::byte_t    mem_operand_i,
	input  wire logic                    load_acc_i,
	output work_regs_pkg::byte_t         acc_o,
	output work_regs_pkg::bank_t         bank_o,
	output logic [4:0]                   bank_base_o
);
	// Datapath state
	byte_t       acc_q;
	byte_t       acc_d;
	byte_t       b_q;
	byte_t       b_d;
	// Status bits 7 to 1; parity is never stored, so it cannot go stale
	logic [7:1]  psw_q;
	logic [7:1]  psw_d;
	// Bus answer state
	logic        ack_q;
	logic        ack_d;
	logic [31:0] dat_q;
	logic [31:0] dat_d;
	// Arithmetic unit
	byte_t       alu_b;
	logic [7:0]  res_a;
	logic [7:0]  res_b;
	logic        carry_n;
	logic        half_n;
	logic        wrap_n;
	logic        upd_c;
	logic        upd_b;
	// Decode and read view
	logic        parity;
	logic [7:0]  byte_addr;
	logic        wr_req;
	logic        rd_req;
	logic [7:0]  psw_full;

	// Register decode reused by read mux and write path
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	alu_unit u_alu (
		.op_i        (op_i),
		.a_i         (acc_q),
		.b_i         (alu_b),
		.carry_i     (psw_q[`BIT_CARRY]),
		.res_a_o     (res_a),
		.res_b_o     (res_b),
		.carry_o     (carry_n),
		.half_o      (half_n),
		.wrap_o      (wrap_n),
		.upd_carry_o (upd_c),
		.upd_b_o     (upd_b)
	);

	assign parity    = ^acc_q; // RQ7
	assign psw_full  = {psw_q, parity}; // RQ6
	assign byte_addr = adr_i[9:2];
	assign wr_req    = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
	assign rd_req    = cyc_i && stb_i && !we_i && !ack_q;
	// Multiply and divide take their second operand from the auxiliary register
	assign alu_b     = (op_i == OP_MUL || op_i == OP_DIV) ? b_q : mem_operand_i; // RQ2

	always_comb
	begin
		acc_d = acc_q;
		b_d   = b_q;
		psw_d = psw_q;
		// Bus writes take precedence over the datapath in the same cycle
		if (op_valid_i)
		begin
			if (load_acc_i)
				acc_d = mem_operand_i; // RQ2
			else
			begin
				acc_d = res_a; // RQ2
				if (upd_b)
					b_d = res_b; // RQ4
				if (upd_c)
				begin
					psw_d[`BIT_CARRY] = carry_n; // RQ3
					psw_d[`BIT_WRAP]  = wrap_n; // RQ3
					if (op_i != OP_MUL && op_i != OP_DIV)
						psw_d[`BIT_HALF_CARRY] = half_n; // RQ3
				end
			end
		end
		if (wr_req)
		begin
			if (hit(byte_addr, `ADDR_WORKING_REG))
				acc_d = dat_i[7:0]; // RQ1
			if (hit(byte_addr, `ADDR_MULDIV_REG))
				b_d = dat_i[7:0]; // RQ5
			if (hit(byte_addr, `ADDR_STATUS_WORD))
			begin
				// Written parity bit is dropped: it only mirrors the working register
				psw_d[`BIT_CARRY]                = dat_i[`BIT_CARRY]; // RQ6
				psw_d[`BIT_HALF_CARRY]           = dat_i[`BIT_HALF_CARRY]; // RQ6
				psw_d[`BIT_USER_ZERO]            = dat_i[`BIT_USER_ZERO]; // RQ6
				psw_d[`BIT_BANK_HI:`BIT_BANK_LO] = dat_i[`BIT_BANK_HI:`BIT_BANK_LO]; // RQ8
				psw_d[`BIT_WRAP]                 = dat_i[`BIT_WRAP]; // RQ6
				psw_d[`BIT_USER_ONE]             = dat_i[`BIT_USER_ONE]; // RQ6
			end
		end
	end

	always_comb
	begin
		ack_d = cyc_i && stb_i && !ack_q;
		dat_d = 32'h0000_0000;
		if (rd_req)
		begin
			if (hit(byte_addr, `ADDR_WORKING_REG))
				dat_d = {24'h00_0000, acc_q}; // RQ1
			else if (hit(byte_addr, `ADDR_MULDIV_REG))
				dat_d = {24'h00_0000, b_q}; // RQ4
			else if (hit(byte_addr, `ADDR_STATUS_WORD))
				dat_d = {24'h00_0000, psw_full}; // RQ7
		end
	end

	// Datapath registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			acc_q <= `RESET_BYTE; // RQ1
			b_q   <= `RESET_BYTE; // RQ4
			psw_q <= 7'h00;
		end
		else
		begin
			acc_q <= acc_d;
			b_q   <= b_d;
			psw_q <= psw_d;
		end
	end

	// Bus answer registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign ack_o       = ack_q;
	assign dat_o       = dat_q;
	assign acc_o       = acc_q;
	assign bank_o      = psw_q[`BIT_BANK_HI:`BIT_BANK_LO]; // RQ8
	assign bank_base_o = {psw_q[`BIT_BANK_HI:`BIT_BANK_LO], 3'b000}; // RQ8
endmodule // working_regs
`default_nettype wire

// ==== shared/work_regs_consts.svh ====
// Contract
// RQ1 - Working register at 0xE0, read/write, resets zero
// RQ2 - Operands and results pass through working register
// RQ3 - Arithmetic results set carry, half-carry, overflow flags; MUL and DIV leave half-carry unchanged, INC and DEC update no flags
// RQ4 - Auxiliary register 0xF0 for multiply/divide, resets zero
// RQ5 - Auxiliary register keeps last write as scratch
// RQ6 - Status word 0xD0 bit layout fixed
// RQ7 - Parity flag read-only, equals working register parity
// RQ8 - Bank select picks one of four register banks
`ifndef WORK_REGS_CONSTS_SVH
`define WORK_REGS_CONSTS_SVH
`define ADDR_STATUS_WORD   8'hd0
`define ADDR_WORKING_REG   8'he0
`define ADDR_MULDIV_REG    8'hf0
`define ADDR_OP_CTRL       8'hc0
`define WB_ADDR_W          10
`define RESET_BYTE         8'h00
`define BIT_CARRY          7
`define BIT_HALF_CARRY     6
`define BIT_USER_ZERO      5
`define BIT_BANK_HI        4
`define BIT_BANK_LO        3
`define BIT_WRAP           2
`define BIT_USER_ONE       1
`define BIT_PARITY         0
`endif

// ==== shared/work_regs_pkg.sv ====
`default_nettype none
package work_regs_pkg;
	typedef enum logic [2:0] {
		OP_ADD,
		OP_ADDC,
		OP_SUBB,
		OP_MUL,
		OP_DIV,
		OP_INC,
		OP_DEC,
		OP_NOP
	} alu_op_t;
	typedef logic [7:0] byte_t;
	typedef logic [1:0] bank_t;
endpackage
`default_nettype wire

// ==== core/alu_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
module alu_unit
	import work_regs_pkg::*;
(
	// Operands
	input  wire work_regs_pkg::alu_op_t op_i,
	input  wire work_regs_pkg::byte_t   a_i,
	input  wire work_regs_pkg::byte_t   b_i,
	input  wire logic                   carry_i,
	// Results
	output logic [7:0]                  res_a_o,
	output logic [7:0]                  res_b_o,
	output logic                        carry_o,
	output logic                        half_o,
	output logic                        wrap_o,
	output logic                        upd_carry_o,
	output logic                        upd_b_o
);
	logic [8:0]  sum;
	logic [4:0]  nib;
	logic [15:0] prod;
	logic        cin;
	logic [7:0]  opb;
	always_comb
	begin
		res_a_o     = a_i;
		res_b_o     = b_i;
		carry_o     = carry_i;
		half_o      = 1'b0;
		wrap_o      = 1'b0;
		upd_carry_o = 1'b0;
		upd_b_o     = 1'b0;
		cin         = 1'b0;
		opb         = b_i;
		prod        = 16'h0000;
		sum         = 9'h000;
		nib         = 5'h00;
		case (op_i)
			OP_ADD, OP_ADDC, OP_SUBB:
			begin
				// Subtract as add of complement; borrow is inverted carry out
				cin = (op_i == OP_ADDC) ? carry_i : 1'b0;
				if (op_i == OP_SUBB)
				begin
					opb = ~b_i;
					cin = ~carry_i;
				end
				sum  = {1'b0, a_i} + {1'b0, opb} + {8'h00, cin};
				nib  = {1'b0, a_i[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
				res_a_o = sum[7:0];
				carry_o = (op_i == OP_SUBB) ? ~sum[8] : sum[8];
				half_o  = (op_i == OP_SUBB) ? ~nib[4] : nib[4];
				wrap_o  = (a_i[7] == opb[7]) && (sum[7] != a_i[7]);
				upd_carry_o = 1'b1;
			end
			OP_MUL:
			begin
				prod    = {8'h00, a_i} * {8'h00, b_i};
				res_a_o = prod[7:0];
				res_b_o = prod[15:8];
				carry_o = 1'b0;
				wrap_o  = |prod[15:8];
				upd_carry_o = 1'b1;
				upd_b_o = 1'b1;
			end
			OP_DIV:
			begin
				// Divide by zero leaves operands and raises the wrap flag
				carry_o = 1'b0;
				upd_carry_o = 1'b1;
				if (b_i == 8'h00)
					wrap_o = 1'b1;
				else
				begin
					res_a_o = a_i / b_i;
					res_b_o = a_i % b_i;
					upd_b_o = 1'b1;
				end
			end
			OP_INC: res_a_o = a_i + 8'h01;
			OP_DEC: res_a_o = a_i - 8'h01;
			default: ;
		endcase
	end
endmodule // alu_unit
`default_nettype wire

// ==== verif/working_regs_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module working_regs_chk
	import work_regs_pkg::*;
(
	// Watched ports
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   cyc_i,
	input wire logic                   stb_i,
	input wire logic                   we_i,
	input wire logic [9:0]             adr_i,
	input wire logic [3:0]             sel_i,
	input wire logic [31:0]            dat_i,
	input wire logic [31:0]            dat_o,
	input wire logic                   ack_o,
	input wire logic                   op_valid_i,
	input wire work_regs_pkg::alu_op_t op_i,
	input wire work_regs_pkg::byte_t   mem_operand_i,
	input wire logic                   load_acc_i,
	input wire work_regs_pkg::byte_t   acc_o,
	input wire work_regs_pkg::bank_t   bank_o,
	input wire logic [4:0]             bank_base_o
);
	wire logic req = cyc_i && stb_i && !ack_o;
	wire logic wr = req && we_i && sel_i[0];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_one_cycle: assert property (req |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse");
	a_acc_bus_write: assert property (wr && adr_i == 10'h380 |=> acc_o == $past(dat_i[7:0]))
		else $error("working register write lost");
	a_acc_mem_load: assert property (op_valid_i && load_acc_i && !wr
		|=> acc_o == $past(mem_operand_i))
		else $error("working register load lost");
	a_acc_inc_step: assert property (op_valid_i && op_i == OP_INC && !load_acc_i && !wr
		|=> acc_o == $past(acc_o) + 8'h01)
		else $error("increment result wrong");
	a_acc_idle_hold: assert property (!(op_valid_i || wr) |=> $stable(acc_o))
		else $error("working register changed while idle");
	a_bank_bus_write: assert property (wr && adr_i == 10'h340 |=> bank_o == $past(dat_i[4:3]))
		else $error("bank field not at bits 4 to 3");
	a_bank_base_map: assert property (bank_base_o == {bank_o, 3'h0})
		else $error("bank base mismatch");
	// Reads are fenced off from ops so the sampled value is the one the slave saw
	a_parity_read: assert property (req && !we_i && adr_i == 10'h340 && !op_valid_i
		|=> dat_o[0] == ^$past(acc_o))
		else $error("parity bit wrong");
endmodule // working_regs_chk
bind working_regs working_regs_chk chk_u (
	.clk_i         (clk_i),
	.rst_i         (rst_i),
	.cyc_i         (cyc_i),
	.stb_i         (stb_i),
	.we_i          (we_i),
	.adr_i         (adr_i),
	.sel_i         (sel_i),
	.dat_i         (dat_i),
	.dat_o         (dat_o),
	.ack_o         (ack_o),
	.op_valid_i    (op_valid_i),
	.op_i          (op_i),
	.mem_operand_i (mem_operand_i),
	.load_acc_i    (load_acc_i),
	.acc_o         (acc_o),
	.bank_o        (bank_o),
	.bank_base_o   (bank_base_o)
);
`default_nettype wire

// ==== verif/test_working_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_working_regs;
	import work_regs_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic        op_valid_i = 1'b0, load_acc_i = 1'b0, ack_o;
	logic [9:0]  adr_i = 10'h0;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o, r;
	alu_op_t     op_i = OP_NOP;
	byte_t       mem_operand_i = 8'h00, acc_o;
	bank_t       bank_o;
	logic [4:0]  bank_base_o;
	int          fail_count = 0, check_count = 0;
	always #50 clk_i = ~clk_i;
	working_regs dut_u (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.cyc_i         (cyc_i),
		.stb_i         (stb_i),
		.we_i          (we_i),
		.adr_i         (adr_i),
		.sel_i         (sel_i),
		.dat_i         (dat_i),
		.dat_o         (dat_o),
		.ack_o         (ack_o),
		.op_valid_i    (op_valid_i),
		.op_i          (op_i),
		.mem_operand_i (mem_operand_i),
		.load_acc_i    (load_acc_i),
		.acc_o         (acc_o),
		.bank_o        (bank_o),
		.bank_base_o   (bank_base_o)
	);
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Ack is sampled on the edge; an idle cycle follows every transfer
	task bus(input logic w, input byte_t a, input byte_t d, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {a, 2'b00};
		sel_i <= s;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input byte_t a, input logic [31:0] e, input string n);
		bus(1'b0, a, 8'h00, 4'h1);
		chk(n, e, r);
	endtask
	task wr(input byte_t a, input byte_t d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task op(input alu_op_t o, input byte_t m, input logic l);
		op_valid_i <= 1'b1;
		op_i <= o;
		mem_operand_i <= m;
		load_acc_i <= l;
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task results;
		if (fail_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'he0, 32'h0, "acc");
		rd(8'hf0, 32'h0, "aux");
		rd(8'hd0, 32'h0, "status");
		wr(8'he0, 8'h5b);
		rd(8'he0, 32'h5b, "acc");
		wr(8'hd0, 8'hfe);
		rd(8'hd0, 32'hff, "status");
		for (int i = 0; i < 4; i++)
		begin
			wr(8'hd0, {3'h0, i[1:0], 3'h0});
			chk("bank_base", {27'h0, i[1:0], 3'h0}, {27'h0, bank_base_o});
			chk("bank", {30'h0, i[1:0]}, {30'h0, bank_o});
		end
		wr(8'hf0, 8'ha5);
		bus(1'b1, 8'hf0, 8'h3c, 4'h0);
		rd(8'hf0, 32'ha5, "aux");
		rd(8'hc4, 32'h0, "unmapped");
		wr(8'hd0, 8'h00);
		op(OP_NOP, 8'h0f, 1'b1);
		op(OP_ADD, 8'hf1, 1'b0);
		chk("acc", 32'h0, {24'h0, acc_o});
		rd(8'hd0, 32'hc0, "status");
		op(OP_INC, 8'h00, 1'b0);
		chk("acc", 32'h1, {24'h0, acc_o});
		op(OP_NOP, 8'h10, 1'b1);
		wr(8'hf0, 8'h20);
		op(OP_MUL, 8'h00, 1'b0);
		chk("acc", 32'h0, {24'h0, acc_o});
		rd(8'hf0, 32'h02, "aux");
		rd(8'hd0, 32'h44, "status");
		op(OP_NOP, 8'h07, 1'b1);
		op(OP_DIV, 8'h00, 1'b0);
		chk("acc", 32'h3, {24'h0, acc_o});
		rd(8'hf0, 32'h01, "aux");
		op(OP_DEC, 8'h00, 1'b0);
		chk("acc", 32'h2, {24'h0, acc_o});
		op(OP_SUBB, 8'h03, 1'b0);
		chk("acc", 32'hff, {24'h0, acc_o});
		rd(8'hd0, 32'hc0, "status");
		op(OP_ADDC, 8'h01, 1'b0);
		chk("acc", 32'h01, {24'h0, acc_o});
		rd(8'hd0, 32'hc1, "status");
		wr(8'hf0, 8'h00);
		op(OP_DIV, 8'h00, 1'b0);
		chk("acc", 32'h01, {24'h0, acc_o});
		rd(8'hd0, 32'h45, "status");
		results();
	end
	// The sequence needs a few hundred cycles at most
	initial
	begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		results();
	end
endmodule // test_working_regs
`default_nettype wire
